//--- hw/umsa_consts.svh
// register addresses, field positions, reset values and timing counts of the modem-status/auto-rate block
`ifndef UMSA_CONSTS_SVH
`define UMSA_CONSTS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define UMSA_MSR_ADDR        32'h4000_8018
`define UMSA_SCR_ADDR        32'h4000_801C
`define UMSA_ACR_ADDR        32'h4000_8020

// ------------------------------------------------------------
// modem_input_status fields
// ------------------------------------------------------------
`define UMSA_MSR_CTS_CHG     0
`define UMSA_MSR_DSR_CHG     1
`define UMSA_MSR_RI_TRAIL    2
`define UMSA_MSR_DCD_CHG     3
`define UMSA_MSR_STATE_LSB   4

// ------------------------------------------------------------
// modem_line_control loopback sources
// ------------------------------------------------------------
`define UMSA_MCR_DSR_BIT     0
`define UMSA_MCR_CTS_BIT     1
`define UMSA_MCR_RI_BIT      2
`define UMSA_MCR_DCD_BIT     3

// ------------------------------------------------------------
// rate_measure_control fields
// ------------------------------------------------------------
`define UMSA_ACR_START       0
`define UMSA_ACR_MODE        1
`define UMSA_ACR_RESTART     2
`define UMSA_ACR_END_CLR     8
`define UMSA_ACR_TO_CLR      9

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define UMSA_SCR_RESET       8'h00
`define UMSA_CNT_WIDTH       16
`define UMSA_PRESCALE        16
`define UMSA_BURST_TICKS     16

`endif

//--- hw/umsa_pkg.sv
// types shared by the modem-status/auto-rate block
package umsa_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } umsa_bus_req_s;

    // active-low modem pins as they arrive at the package
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } umsa_modem_s;

    typedef enum logic [1:0] {
        UMSA_IDLE    = 2'b00,
        UMSA_WAIT_FE = 2'b01,
        UMSA_MEASURE = 2'b10
    } umsa_state_e;

endpackage

//--- hw/umsa_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module umsa_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET = '1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // the first stage feeds the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= RESET;
            sync_out <= RESET;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- hw/umsa_edge.sv
// rising and falling edge detector on synchronised levels
`timescale 1ns/100ps
module umsa_edge #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= RESET;
        end else begin
            prev_r <= level;
        end
    end

    assign rise = level & ~prev_r;
    assign fall = ~level & prev_r;
endmodule

//--- hw/umsa_top.sv
// modem input status, scratch byte and automatic rate measurement of a uart
//
// Notes on behaviour
// - reading modem status clears its four change flags, state bits untouched
// - cts, dsr, dcd change flags set on any change of that input
// - ring flag set only when active-low ring input goes low to high
// - status bits 7:4 show inverted cts, dsr, ri, dcd; reset to zero
// - in loopback the state bits come from line control bits 1,0,2,3
// - modem inputs never steer transmit or receive, only reported
// - scratch byte, free read/write, resets zero, no side effects
// - start bit launches, clearing aborts, hardware clears it on finish
// - mode 0 times fall to fall, mode 1 times fall to rise
// - with auto restart, overflow restarts at next receive falling edge
// - overflow sets time-out flag when its enable is set
// - successful finish sets end flag when its enable is set
// - control bits 8 and 9 written one clear end and time-out flags
// - measurable rates bounded by counter width and prescale of sixteen
// - start resets counter and receive shifter, selects highest sample rate
// - first falling edge after start begins counting clock cycles
// - sixteen receive ticks at clock rate during the start bit
// - counting stops on next fall in mode 0, next rise in mode 1
// - result loads divisor latches, normal rate resumes, end flag follows
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "umsa_consts.svh"
module umsa_top #(
    parameter int CNT_W    = `UMSA_CNT_WIDTH,
    parameter int PRESCALE = `UMSA_PRESCALE
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire umsa_pkg::umsa_bus_req_s bus_req,
    output logic [31:0]                rdata,
    input  wire umsa_pkg::umsa_modem_s modem_pins,
    input  wire logic                  rx_pin,
    input  wire logic                  loopback_en,
    input  wire logic [3:0]            modem_line_control,
    input  wire logic                  end_int_en,
    input  wire logic                  timeout_int_en,
    output logic                       measure_end_flag,
    output logic                       measure_timeout_flag,
    output logic                       divisor_load,
    output logic [15:0]                divisor_value,
    output logic                       rx_shift_reset,
    output logic                       rx_fast_rate,
    output logic                       rx_burst_tick
);
    import umsa_pkg::*;

    localparam int PS_W    = $clog2(PRESCALE);
    localparam int BURST_W = $clog2(`UMSA_BURST_TICKS + 1);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
        hit = (a == target);
    endfunction

    logic rd_msr;
    logic wr_scr;
    logic wr_acr;
    assign rd_msr        = bus_req.rd && hit(bus_req.addr, `UMSA_MSR_ADDR);
    assign wr_scr        = bus_req.wr && hit(bus_req.addr, `UMSA_SCR_ADDR);
    assign wr_acr        = bus_req.wr && hit(bus_req.addr, `UMSA_ACR_ADDR);

    // ------------------------------------------------------------
    // pin synchronisers and edge detectors
    // ------------------------------------------------------------
    logic [3:0] pins_sync;
    logic       rx_sync;

    umsa_sync #(.WIDTH(4), .RESET(4'hF)) u_modem_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (modem_pins),
        .sync_out (pins_sync)
    );

    umsa_sync #(.WIDTH(1), .RESET(1'b1)) u_rx_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (rx_pin),
        .sync_out (rx_sync)
    );

    // state order {dcd, ri, dsr, cts}; pins idle high so states reset to zero
    logic [3:0] modem_state;
    logic [3:0] state_rise;
    logic [3:0] state_fall;
    logic       rx_rise;
    logic       rx_fall;

    always_comb begin
        if (loopback_en) begin
            modem_state[0] = modem_line_control[`UMSA_MCR_CTS_BIT];
            modem_state[1] = modem_line_control[`UMSA_MCR_DSR_BIT];
            modem_state[2] = modem_line_control[`UMSA_MCR_RI_BIT];
            modem_state[3] = modem_line_control[`UMSA_MCR_DCD_BIT];
        end else begin
            modem_state = ~pins_sync;
        end
    end

    umsa_edge #(.WIDTH(4), .RESET(4'h0)) u_modem_edge (
        .clk   (clk),
        .rst_n (rst_n),
        .level (modem_state),
        .rise  (state_rise),
        .fall  (state_fall)
    );

    umsa_edge #(.WIDTH(1), .RESET(1'b1)) u_rx_edge (
        .clk   (clk),
        .rst_n (rst_n),
        .level (rx_sync),
        .rise  (rx_rise),
        .fall  (rx_fall)
    );

    // ------------------------------------------------------------
    // modem change flags
    // ------------------------------------------------------------
    // the modem inputs end here: nothing below feeds the shift logic
    logic [3:0] chg_set;
    logic [3:0] chg_r;

    assign chg_set[0] = state_rise[0] | state_fall[0];
    assign chg_set[1] = state_rise[1] | state_fall[1];
    assign chg_set[2] = state_fall[2];
    assign chg_set[3] = state_rise[3] | state_fall[3];

    // a change landing on the clearing read is kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_r <= 4'h0;
        end else begin
            chg_r <= chg_set | (rd_msr ? 4'h0 : chg_r);
        end
    end

    // ------------------------------------------------------------
    // scratch byte
    // ------------------------------------------------------------
    logic [7:0] scratch_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scratch_r <= `UMSA_SCR_RESET;
        end else if (wr_scr) begin
            scratch_r <= bus_req.wdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // rate measurement control
    // ------------------------------------------------------------
    umsa_state_e state_r;
    logic        mode_r;
    logic        restart_r;
    logic        start_req;
    logic        abort_req;
    logic        overflow;
    logic        done;
    logic [PS_W-1:0]  ps_r;
    logic [CNT_W-1:0] cnt_r;
    logic [BURST_W-1:0] burst_r;

    assign start_req = wr_acr && bus_req.wdata[`UMSA_ACR_START] && (state_r == UMSA_IDLE);
    assign abort_req = wr_acr && !bus_req.wdata[`UMSA_ACR_START];
    assign overflow  = (state_r == UMSA_MEASURE) && (ps_r == PS_W'(PRESCALE - 1)) && (&cnt_r);
    assign done      = (state_r == UMSA_MEASURE) && !overflow &&
                       (mode_r ? rx_rise : rx_fall);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r    <= 1'b0;
            restart_r <= 1'b0;
        end else if (wr_acr) begin
            mode_r    <= bus_req.wdata[`UMSA_ACR_MODE];
            restart_r <= bus_req.wdata[`UMSA_ACR_RESTART];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= UMSA_IDLE;
        end else if (abort_req) begin
            state_r <= UMSA_IDLE;
        end else begin
            case (state_r)
                UMSA_IDLE: begin
                    if (start_req) begin
                        state_r <= UMSA_WAIT_FE;
                    end
                end
                UMSA_WAIT_FE: begin
                    if (rx_fall) begin
                        state_r <= UMSA_MEASURE;
                    end
                end
                UMSA_MEASURE: begin
                    if (overflow) begin
                        state_r <= restart_r ? UMSA_WAIT_FE : UMSA_IDLE;
                    end else if (done) begin
                        state_r <= UMSA_IDLE;
                    end
                end
                default: begin
                    state_r <= UMSA_IDLE;
                end
            endcase
        end
    end

    // counter advances once per PRESCALE clocks, so it holds the timed span (one bit in mode 1, two in mode 0) over sixteen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_r  <= '0;
            cnt_r <= '0;
        end else if (state_r != UMSA_MEASURE) begin
            ps_r  <= '0;
            cnt_r <= '0;
        end else begin
            ps_r <= (ps_r == PS_W'(PRESCALE - 1)) ? '0 : ps_r + PS_W'(1);
            if (ps_r == PS_W'(PRESCALE - 1)) begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end

    // start bit must reach the shifter while the divisor is still unknown
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_r <= '0;
        end else if (state_r == UMSA_WAIT_FE && rx_fall) begin
            burst_r <= BURST_W'(`UMSA_BURST_TICKS);
        end else if (burst_r != '0) begin
            burst_r <= burst_r - BURST_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_burst_tick  <= 1'b0;
            rx_shift_reset <= 1'b0;
            rx_fast_rate   <= 1'b0;
        end else begin
            rx_burst_tick  <= (state_r == UMSA_WAIT_FE && rx_fall) || (burst_r > BURST_W'(1));
            rx_shift_reset <= start_req;
            rx_fast_rate   <= (start_req || state_r != UMSA_IDLE) && !done && !abort_req;
        end
    end

    // mode 0 spans two bits, so halve; a zero divisor would stall the generator
    logic [CNT_W-1:0] measured;
    always_comb begin
        measured = mode_r ? cnt_r : (cnt_r >> 1);
        if (measured == '0) begin
            measured = CNT_W'(1);
        end
    end

    // old latch contents are simply overwritten
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divisor_load  <= 1'b0;
            divisor_value <= 16'h0000;
        end else begin
            divisor_load <= done;
            if (done) begin
                divisor_value <= 16'(measured);
            end
        end
    end

    // ------------------------------------------------------------
    // end and time-out flags (set wins over clear)
    // ------------------------------------------------------------
    logic end_clr;
    logic to_clr;
    assign end_clr = wr_acr && bus_req.wdata[`UMSA_ACR_END_CLR];
    assign to_clr  = wr_acr && bus_req.wdata[`UMSA_ACR_TO_CLR];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            measure_end_flag <= 1'b0;
        end else if (divisor_load && end_int_en) begin
            measure_end_flag <= 1'b1;
        end else if (end_clr) begin
            measure_end_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            measure_timeout_flag <= 1'b0;
        end else if (overflow && timeout_int_en) begin
            measure_timeout_flag <= 1'b1;
        end else if (to_clr) begin
            measure_timeout_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic start_bit;
    assign start_bit = (state_r != UMSA_IDLE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (!bus_req.rd) begin
            rdata <= 32'h0000_0000;
        end else if (hit(bus_req.addr, `UMSA_MSR_ADDR)) begin
            rdata <= {24'h000000, modem_state, chg_r};
        end else if (hit(bus_req.addr, `UMSA_SCR_ADDR)) begin
            rdata <= {24'h000000, scratch_r};
        end else if (hit(bus_req.addr, `UMSA_ACR_ADDR)) begin
            rdata <= {29'h0, restart_r, mode_r, start_bit};
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_launch;
        start_req ##1 (state_r == UMSA_WAIT_FE);
    endsequence

    sequence s_finish;
        done ##1 divisor_load;
    endsequence

    a_msr_read_clear: assert property (rd_msr && chg_set == 4'h0 |=> chg_r == 4'h0)
        else $error("change flags survived a status read");
    a_change_capture: assert property (chg_set[0] |=> chg_r[0] ##1 rdata[0] || !$past(rd_msr))
        else $error("cts change not captured");
    a_ring_trailing: assert property ($rose(chg_r[2]) |-> $past(state_fall[2]))
        else $error("ring flag set without trailing edge");
    a_scratch_hold: assert property (!wr_scr |=> $stable(scratch_r))
        else $error("scratch byte changed without a write");
    a_launch_reset: assert property (s_launch |-> rx_shift_reset && cnt_r == '0)
        else $error("launch did not reset shifter and counter");
    a_burst_count: assert property (state_r == UMSA_WAIT_FE && rx_fall |=> rx_burst_tick [*8] ##1
                                    rx_burst_tick [*8] ##1 !rx_burst_tick)
        else $error("start bit tick burst is not sixteen long");
    a_finish_load: assert property (s_finish |-> divisor_value == $past(measured) && state_r == UMSA_IDLE)
        else $error("measured value not loaded at finish");
    a_end_flag: assert property (divisor_load && end_int_en |=> measure_end_flag)
        else $error("end flag missing after finish");
    a_timeout_flag: assert property (overflow && timeout_int_en |=> measure_timeout_flag)
        else $error("time-out flag missing after overflow");
    a_auto_restart: assert property (overflow && restart_r && !abort_req |=> state_r == UMSA_WAIT_FE)
        else $error("no restart after overflow");
    a_flag_clear: assert property (end_clr && !(divisor_load && end_int_en) |=> !measure_end_flag)
        else $error("end flag not cleared by write");
    a_abort_stop: assert property (abort_req |=> state_r == UMSA_IDLE && !rx_fast_rate)
        else $error("measurement not aborted");
endmodule

//--- bench/umsa_remote.sv
// remote terminal model: drives the serial receive line and the modem pins
`timescale 1ns/100ps
module umsa_remote (
    input  wire logic             clk,
    output logic                  rx,
    output umsa_pkg::umsa_modem_s pins
);
    import umsa_pkg::*;

    // line idles high; all modem pins released (inactive high)
    initial begin
        rx = 1'b1;
        pins = '1;
    end

    // start bit, eight data bits lsb first, one stop bit
    task automatic send_char(input logic [7:0] c, input int bit_clks);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rx <= f[i];
            repeat (bit_clks) @(posedge clk);
        end
    endtask

    // a stuck-low line, long enough to overflow the rate counter
    task automatic hold_low(input int n);
        @(posedge clk);
        rx <= 1'b0;
        repeat (n) @(posedge clk);
        rx <= 1'b1;
    endtask

    task automatic set_pins(input logic [3:0] v);
        @(posedge clk);
        pins <= v;
    endtask
endmodule

//--- bench/tb_umsa_top.sv
// self-checking bench for the modem status, scratch byte and auto-rate block
`timescale 1ns/100ps
`include "umsa_consts.svh"
module tb_umsa_top;
    import umsa_pkg::*;
    // 8.5 prescale periods a bit keeps truncation clear of a boundary
    localparam int BIT_CLKS = 136;
    // narrow counter so that an overflow takes about a thousand cycles
    localparam int CNT_W    = 6;
    logic          clk, rst_n, rx_pin, loopback_en, end_int_en, timeout_int_en;
    logic          end_f, to_f, divisor_load, rx_shift_reset, rx_fast_rate, rx_burst_tick;
    umsa_bus_req_s bus_req;
    umsa_modem_s   modem_pins;
    logic [31:0]   rdata, st;
    logic [15:0]   divisor_value;
    logic [3:0]    modem_line_control, pv;
    int            errors, comparisons;

    umsa_top #(.CNT_W(CNT_W), .PRESCALE(`UMSA_PRESCALE)) u_umsa_top (
        .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .modem_pins(modem_pins),
        .rx_pin(rx_pin), .loopback_en(loopback_en), .modem_line_control(modem_line_control),
        .end_int_en(end_int_en), .timeout_int_en(timeout_int_en), .measure_end_flag(end_f),
        .measure_timeout_flag(to_f), .divisor_load(divisor_load), .divisor_value(divisor_value),
        .rx_shift_reset(rx_shift_reset), .rx_fast_rate(rx_fast_rate), .rx_burst_tick(rx_burst_tick));
    umsa_remote u_umsa_remote (.clk(clk), .rx(rx_pin), .pins(modem_pins));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 chk(rdata & m, exp);
    endtask

    task automatic wait_hi(input int w, input int lim);
        int k;
        k = 0;
        while ((w == 0 ? rx_burst_tick : divisor_load) !== 1'b1 && k < lim) begin
            @(posedge clk);
            #1 k++;
        end
        if (k >= lim) chk(32'h0, 32'h1);
    endtask

    task automatic start(input logic [31:0] v);
        wr(`UMSA_ACR_ADDR, v);
        chk(32'(rx_shift_reset), 32'h1);
        chk(32'(rx_fast_rate), 32'h1);
    endtask

    // one 'A'/'a' character; both modes yield a divisor of eight
    task automatic measure(input logic [7:0] c);
        int k;
        fork
            u_umsa_remote.send_char(c, BIT_CLKS);
            begin
                wait_hi(0, 300);
                k = 0;
                while (rx_burst_tick === 1'b1) begin
                    k++;
                    @(posedge clk);
                    #1;
                end
                chk(32'(k), 32'h10);
                wait_hi(1, 600);
                chk(32'(divisor_value), 32'h8);
                chk(32'(rx_fast_rate), 32'h0);
            end
        join
    endtask

    task automatic close_out;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        errors++;
        close_out;
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        loopback_en = 1'b0;
        modem_line_control = 4'h0;
        end_int_en = 1'b0;
        timeout_int_en = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`UMSA_MSR_ADDR, 32'h0);
        rd_chk(`UMSA_SCR_ADDR, 32'h0);
        rd_chk(`UMSA_ACR_ADDR, 32'h0);
        rd_chk(32'h4000_8024, 32'h0);
        wr(`UMSA_SCR_ADDR, 32'hFFFF_FF5A);
        rd_chk(`UMSA_SCR_ADDR, 32'h5A);
        chk({30'h0, end_f, to_f}, 32'h0);
        // pins go active one at a time, then release in the same order
        st = 32'h0;
        pv = 4'hF;
        for (int i = 0; i < 4; i++) begin
            pv[i] = 1'b0;
            u_umsa_remote.set_pins(pv);
            repeat (5) @(posedge clk);
            st[4+i] = 1'b1;
            rd_chk(`UMSA_MSR_ADDR, st | ((i == 2) ? 32'h0 : 32'h1 << i));
            rd_chk(`UMSA_MSR_ADDR, st);
        end
        for (int i = 0; i < 4; i++) begin
            pv[i] = 1'b1;
            u_umsa_remote.set_pins(pv);
            repeat (5) @(posedge clk);
            st[4+i] = 1'b0;
            rd_chk(`UMSA_MSR_ADDR, st | 32'h1 << i);
        end
        chk({29'h0, rx_fast_rate, divisor_load, rx_burst_tick}, 32'h0);
        @(posedge clk);
        loopback_en <= 1'b1;
        modem_line_control <= 4'h5;
        repeat (5) @(posedge clk);
        rd_chk(`UMSA_MSR_ADDR, 32'h60, 32'hF0);
        modem_line_control <= 4'hA;
        repeat (5) @(posedge clk);
        rd_chk(`UMSA_MSR_ADDR, 32'h90, 32'hF0);
        loopback_en <= 1'b0;
        repeat (5) @(posedge clk);
        rd_chk(`UMSA_MSR_ADDR, 32'h0, 32'hF0);
        // no divisor writes follow a control write in this bench
        end_int_en <= 1'b1;
        start(32'h3);
        rd_chk(`UMSA_ACR_ADDR, 32'h3);
        measure(8'h41);
        rd_chk(`UMSA_ACR_ADDR, 32'h2);
        chk(32'(end_f), 32'h1);
        wr(`UMSA_ACR_ADDR, 32'h2);
        chk(32'(end_f), 32'h1);
        wr(`UMSA_ACR_ADDR, 32'h102);
        chk(32'(end_f), 32'h0);
        end_int_en <= 1'b0;
        start(32'h1);
        measure(8'h61);
        chk(32'(end_f), 32'h0);
        start(32'h3);
        wr(`UMSA_ACR_ADDR, 32'h2);
        rd_chk(`UMSA_ACR_ADDR, 32'h2);
        chk(32'(rx_fast_rate), 32'h0);
        end_int_en <= 1'b1;
        timeout_int_en <= 1'b1;
        start(32'h3);
        u_umsa_remote.hold_low(1100);
        chk(32'(to_f), 32'h1);
        rd_chk(`UMSA_ACR_ADDR, 32'h2);
        wr(`UMSA_ACR_ADDR, 32'h202);
        chk(32'(to_f), 32'h0);
        start(32'h7);
        u_umsa_remote.hold_low(1100);
        chk(32'(to_f), 32'h1);
        rd_chk(`UMSA_ACR_ADDR, 32'h7);
        measure(8'h41);
        chk(32'(end_f), 32'h1);
        close_out;
    end
endmodule
